// ===== vdsr_pkg.sv
// Constants shared by the video decoder status readback block.
// Assumes an 8-bit host register port with byte addresses as printed.
package vdsr_pkg;
  localparam logic [7:0] VDSR_OFS_STATUS_TWO = 8'h82;
  localparam logic [7:0] VDSR_OFS_AGC_GAIN   = 8'h83;
  localparam logic [7:0] VDSR_OFS_SCH_PHASE  = 8'h84;
  localparam logic [7:0] VDSR_OFS_EVENTS_B   = 8'h85;
  localparam logic [7:0] VDSR_OFS_IRQ_ACTIVE = 8'h86;
  localparam logic [7:0] VDSR_OFS_FW_MINOR   = 8'h87;
  localparam logic [7:0] VDSR_OFS_STANDARD   = 8'h88;
  localparam logic [7:0] VDSR_OFS_LINE_HIGH  = 8'h89;
  localparam logic [7:0] VDSR_OFS_LINE_LOW   = 8'h8a;
  localparam logic [7:0] VDSR_OFS_IRQ_RESET  = 8'h1c;
  localparam logic [7:0] VDSR_OFS_IRQ_ENABLE = 8'h1d;

  localparam int VDSR_BIT_PAL_SWITCH = 5;
  localparam int VDSR_BIT_FIELD_ODD  = 4;
  localparam int VDSR_BIT_AGC_FROZEN = 3;
  localparam int VDSR_BIT_CMD_READY  = 5;
  localparam int VDSR_BIT_INIT_DONE  = 7;
  localparam int VDSR_NUM_EVENTS     = 5;
  localparam int VDSR_STD_LSB        = 1;

  localparam logic [4:0] VDSR_EVENTS_RST = 5'h00;
  localparam logic [4:0] VDSR_ENABLE_RST = 5'h00;
  localparam logic [7:0] VDSR_ZERO_BYTE  = 8'h00;
  // Arbitrary revision value, within 0 to 99
  localparam logic [7:0] VDSR_FW_MINOR_DEF = 8'h00;
  localparam logic [6:0] VDSR_FW_MINOR_MAX = 7'h63;

  typedef enum logic [2:0] {
    VDSR_STD_NTSC_M   = 3'h0,
    VDSR_STD_PAL_BGHI = 3'h1,
    VDSR_STD_PAL_M    = 3'h2,
    VDSR_STD_PAL_CN   = 3'h3,
    VDSR_STD_NTSC_443 = 3'h4
  } vdsr_std_t;
endpackage

// ===== vdsr_sync2.sv
// Two flip-flop synchroniser for a bundle of status levels.
// Assumes the inputs come from outside the clk_in domain.
module vdsr_sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         sys_rst_in,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } vdsr_sync_t;

  vdsr_sync_t st_r;
  vdsr_sync_t st_nxt;

  always_comb begin
    st_nxt.meta   = async_in;
    st_nxt.stable = st_r.meta;
    if (sys_rst_in) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge clk_in) begin
    st_r <= st_nxt;
  end

  assign sync_out = st_r.stable;
endmodule

// ===== vdsr_event_flag.sv
// One sticky change flag: set by a status edge, cleared by host write-one.
// Assumes the status level is already on clk_in.
module vdsr_event_flag (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  // Event and clear
  input  wire logic level_in,
  input  wire logic clear_in,
  output logic      flag_out
);
  typedef struct packed {
    logic last;
    logic flag;
  } vdsr_flag_t;

  vdsr_flag_t st_r;
  vdsr_flag_t st_nxt;
  logic       change;

  assign change = level_in ^ st_r.last;

  always_comb begin
    st_nxt.last = level_in;
    // Set wins over a clear in the same cycle
    st_nxt.flag = change | (st_r.flag & ~clear_in);
    if (sys_rst_in) begin
      st_nxt.last = level_in;
      st_nxt.flag = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    st_r <= st_nxt;
  end

  assign flag_out = st_r.flag;

  chk_flag_sticky: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    st_r.flag && !clear_in |=> st_r.flag) else $error("flag dropped without clear");
  chk_flag_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    st_r.flag && clear_in && !change |=> !st_r.flag) else $error("flag not cleared");
  chk_flag_set: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    $changed(level_in) && !$past(sys_rst_in) |=> st_r.flag) else $error("change not flagged");
endmodule

// ===== vdsr_top.sv
// Status readback register bank of a video decoder with interrupt B logic.
// Assumes the host port gives a one-cycle read or write strobe with address
// and data on clk_in; status levels arrive from other logic asynchronously.
module vdsr_top
  import vdsr_pkg::*;
#(
  parameter logic [7:0] FW_MINOR = vdsr_pkg::VDSR_FW_MINOR_DEF
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // Host register port
  input  wire logic        host_rd_in,
  input  wire logic        host_wr_in,
  input  wire logic [7:0]  host_addr_in,
  input  wire logic [7:0]  host_wdata_in,
  output logic      [7:0]  host_rdata_out,
  output logic             host_rvalid_out,
  // Decoder status levels
  input  wire logic        pal_switch_in,
  input  wire logic        field_odd_in,
  input  wire logic        agc_frozen_in,
  input  wire logic [7:0]  agc_gain_in,
  input  wire logic [7:0]  subcarrier_to_hsync_phase_in,
  input  wire logic        sch_sample_in,
  input  wire logic        source_type_in,
  input  wire logic        hv_lock_in,
  input  wire logic        color_lock_in,
  input  wire logic        line_alt_in,
  input  wire logic        field_rate_in,
  input  wire logic        command_accept_ready_in,
  input  wire logic        init_done_in,
  input  wire vdsr_pkg::vdsr_std_t std_in,
  input  wire logic        square_pixel_in,
  input  wire logic [9:0]  line_count_in,
  // Interrupt pin, active high level
  output logic             irq_b_out
);
  import vdsr_pkg::*;

  localparam int SW = 41;

  typedef struct packed {
    logic [7:0] rdata;
    logic       rvalid;
    logic [4:0] enable;
    logic [7:0] subcarrier_to_hsync_phase;
    logic       sch_seen;
    logic       irq;
  } vdsr_state_t;

  vdsr_state_t st_r;
  vdsr_state_t st_nxt;

  logic [SW-1:0] raw_bus;
  logic [SW-1:0] syn_bus;
  logic          s_pal;
  logic          s_field;
  logic          s_frozen;
  logic [7:0]    s_gain;
  logic [7:0]    s_phase;
  logic          s_sample;
  logic [4:0]    s_status;
  logic          s_ready;
  logic          s_init;
  logic [2:0]    s_std;
  logic          s_square;
  logic [9:0]    s_line;
  logic [4:0]    flags;
  logic [4:0]    clear;
  logic          wr_reset;
  logic          sample_rise;
  logic [7:0]    rd_mux;

  // All status inputs pass two flip-flops before use
  assign raw_bus = {pal_switch_in, field_odd_in, agc_frozen_in, agc_gain_in,
                    subcarrier_to_hsync_phase_in, sch_sample_in,
                    field_rate_in, line_alt_in, color_lock_in, hv_lock_in,
                    source_type_in, command_accept_ready_in, init_done_in,
                    std_in, square_pixel_in, line_count_in};

  vdsr_sync2 #(
    .W (SW)
  ) u_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .async_in   (raw_bus),
    .sync_out   (syn_bus)
  );

  assign {s_pal, s_field, s_frozen, s_gain, s_phase, s_sample, s_status,
          s_ready, s_init, s_std, s_square, s_line} = syn_bus;

  assign wr_reset = host_wr_in && (host_addr_in == VDSR_OFS_IRQ_RESET);
  assign clear    = wr_reset ? host_wdata_in[4:0] : 5'h00;

  genvar gi;
  generate
    for (gi = 0; gi < VDSR_NUM_EVENTS; gi++) begin : g_flag
      vdsr_event_flag u_flag (
        .clk_in     (clk_in),
        .sys_rst_in (sys_rst_in),
        .level_in   (s_status[gi]),
        .clear_in   (clear[gi]),
        .flag_out   (flags[gi])
      );
    end
  endgenerate

  // Phase is captured on the rising edge of the synchronised sample strobe
  assign sample_rise = s_sample && !st_r.sch_seen;

  always_comb begin
    rd_mux = VDSR_ZERO_BYTE;
    unique case (host_addr_in)
      VDSR_OFS_STATUS_TWO: begin
        rd_mux[VDSR_BIT_PAL_SWITCH] = s_pal;
        rd_mux[VDSR_BIT_FIELD_ODD]  = s_field;
        rd_mux[VDSR_BIT_AGC_FROZEN] = s_frozen;
      end
      VDSR_OFS_AGC_GAIN: begin
        rd_mux = s_gain;
      end
      VDSR_OFS_SCH_PHASE: begin
        rd_mux = st_r.subcarrier_to_hsync_phase;
      end
      VDSR_OFS_EVENTS_B: begin
        rd_mux[4:0]                = flags;
        rd_mux[VDSR_BIT_CMD_READY] = s_ready;
        rd_mux[VDSR_BIT_INIT_DONE] = s_init;
      end
      VDSR_OFS_IRQ_ACTIVE: begin
        rd_mux[0] = st_r.irq;
      end
      VDSR_OFS_FW_MINOR: begin
        rd_mux = (FW_MINOR > {1'b0, VDSR_FW_MINOR_MAX}) ?
                 {1'b0, VDSR_FW_MINOR_MAX} : FW_MINOR;
      end
      VDSR_OFS_STANDARD: begin
        rd_mux[0]                  = s_square;
        rd_mux[VDSR_STD_LSB +: 3]  = s_std;
      end
      VDSR_OFS_LINE_HIGH: begin
        rd_mux[1:0] = s_line[9:8];
      end
      VDSR_OFS_LINE_LOW: begin
        rd_mux = s_line[7:0];
      end
      VDSR_OFS_IRQ_ENABLE: begin
        rd_mux[4:0] = st_r.enable;
      end
      default: begin
        rd_mux = VDSR_ZERO_BYTE;
      end
    endcase
  end

  always_comb begin
    st_nxt          = st_r;
    st_nxt.rvalid   = host_rd_in;
    st_nxt.rdata    = host_rd_in ? rd_mux : st_r.rdata;
    st_nxt.sch_seen = s_sample;
    if (sample_rise) begin
      st_nxt.subcarrier_to_hsync_phase = s_phase;
    end
    // Only the enable and interrupt reset registers take writes; status writes are dropped
    if (host_wr_in && host_addr_in == VDSR_OFS_IRQ_ENABLE) begin
      st_nxt.enable = host_wdata_in[4:0];
    end
    st_nxt.irq = |(flags & st_r.enable);
    if (sys_rst_in) begin
      st_nxt.rdata    = VDSR_ZERO_BYTE;
      st_nxt.rvalid   = 1'b0;
      st_nxt.enable   = VDSR_ENABLE_RST;
      st_nxt.subcarrier_to_hsync_phase      = VDSR_ZERO_BYTE;
      st_nxt.sch_seen = 1'b0;
      st_nxt.irq      = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    st_r <= st_nxt;
  end

  assign host_rdata_out  = st_r.rdata;
  assign host_rvalid_out = st_r.rvalid;
  assign irq_b_out       = st_r.irq;

  chk_irq_follows: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    |(flags & st_r.enable) |=> irq_b_out) else $error("irq not raised");
  chk_irq_masked: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    (st_r.enable == 5'h00) ##1 (st_r.enable == 5'h00) |-> !irq_b_out)
    else $error("masked irq active");
  chk_active_reg: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    host_rd_in && host_addr_in == VDSR_OFS_IRQ_ACTIVE |=>
    host_rdata_out == {7'h00, $past(irq_b_out)}) else $error("active read wrong");
  chk_line_high: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    host_rd_in && host_addr_in == VDSR_OFS_LINE_HIGH |=>
    host_rdata_out[7:2] == 6'h00) else $error("line high reserved set");
  chk_status_resv: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    host_rd_in && host_addr_in == VDSR_OFS_STATUS_TWO |=>
    (host_rdata_out & 8'hc7) == 8'h00) else $error("status two reserved set");
  chk_fw_range: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    host_rd_in && host_addr_in == VDSR_OFS_FW_MINOR |=>
    host_rdata_out <= 8'h63) else $error("revision out of range");
  chk_events_resv: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    host_rd_in && host_addr_in == VDSR_OFS_EVENTS_B |=>
    !host_rdata_out[6]) else $error("events bit6 set");
  chk_read_valid: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    host_rd_in |=> host_rvalid_out ##1 !host_rvalid_out || $past(host_rd_in))
    else $error("read valid timing");
  chk_sch_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in)
    !sample_rise |=> $stable(st_r.subcarrier_to_hsync_phase)) else $error("phase changed off strobe");
endmodule

// ===== vdsr_host_model.sv
// Host processor model driving the register port of the status block.
// Assumes a one-cycle strobe per access and a read answer within 4 cycles.
module vdsr_host_model (
  // Clock
  input  wire logic       clk_in,
  // Host port
  output logic            rd_out,
  output logic            wr_out,
  output logic      [7:0] addr_out,
  output logic      [7:0] wdata_out,
  input  wire logic [7:0] rdata_in,
  input  wire logic       rvalid_in,
  // Answer never came
  output logic            timeout_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rd_out = 1'b0;
    wr_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
    timeout_out = 1'b0;
  end
  // Released lines show the inverse so stale values never pass
  task bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    wr_out <= 1'b1;
    addr_out <= a;
    wdata_out <= d;
    @(posedge clk_in);
    wr_out <= 1'b0;
    addr_out <= ~a;
    wdata_out <= ~d;
  endtask
  task bus_rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    rd_out <= 1'b1;
    addr_out <= a;
    @(posedge clk_in);
    rd_out <= 1'b0;
    addr_out <= ~a;
    #1;
    while (rvalid_in !== 1'b1 && n < 4) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    d = rdata_in;
    if (rvalid_in !== 1'b1) timeout_out = 1'b1;
  endtask
endmodule

// ===== tb.sv
// Self-checking bench for the status readback block.
// Assumes the host model tasks are reached through its instance.
module tb;
  import vdsr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_in, sys_rst_in, pal, fld, frz, subcarrier_to_hsync_phase, rdy, ini, sq;
  logic [4:0] ev;
  logic [7:0] gain, ph, v;
  logic [9:0] line;
  vdsr_std_t  std;
  wire logic  rd, wr, rv, irq, tmo;
  wire logic [7:0] addr, wdata, rdat;
  int         err_count = 0;
  int         total_checks = 0;

  vdsr_top #(.FW_MINOR(8'h2a)) vdsr_top_inst (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .host_rd_in(rd), .host_wr_in(wr), .host_addr_in(addr), .host_wdata_in(wdata),
    .host_rdata_out(rdat), .host_rvalid_out(rv), .pal_switch_in(pal), .field_odd_in(fld),
    .agc_frozen_in(frz), .agc_gain_in(gain), .subcarrier_to_hsync_phase_in(ph),
    .sch_sample_in(subcarrier_to_hsync_phase), .source_type_in(ev[0]), .hv_lock_in(ev[1]), .color_lock_in(ev[2]),
    .line_alt_in(ev[3]), .field_rate_in(ev[4]), .command_accept_ready_in(rdy),
    .init_done_in(ini), .std_in(std), .square_pixel_in(sq), .line_count_in(line),
    .irq_b_out(irq));
  vdsr_host_model vdsr_host_model_inst (.clk_in(clk_in), .rd_out(rd), .wr_out(wr),
    .addr_out(addr), .wdata_out(wdata), .rdata_in(rdat), .rvalid_in(rv), .timeout_out(tmo));

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge tmo) begin
    err_count++;
    report_and_stop;
  end
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] e);
    vdsr_host_model_inst.bus_rd(a, v);
    chk($sformatf("reg %h", a), e, v);
  endtask
  // Inputs pass two sync stages and the read register
  task settle;
    repeat (4) @(posedge clk_in);
  endtask
  task t_status;
    pal <= 1'b1;
    frz <= 1'b1;
    gain <= 8'ha5;
    line <= 10'h2c7;
    settle;
    rdchk(8'h82, 8'h28);
    vdsr_host_model_inst.bus_wr(8'h82, 8'hff);
    rdchk(8'h82, 8'h28);
    rdchk(8'h83, 8'ha5);
    rdchk(8'h89, 8'h02);
    rdchk(8'h8a, 8'hc7);
    pal <= 1'b0;
    fld <= 1'b1;
    frz <= 1'b0;
    settle;
    rdchk(8'h82, 8'h10);
    for (int i = 0; i < 5; i++) begin
      std <= vdsr_std_t'(i);
      sq <= i[0];
      settle;
      rdchk(8'h88, {4'h0, i[2:0], i[0]});
    end
  endtask
  task t_phase;
    ph <= 8'h5a;
    settle;
    subcarrier_to_hsync_phase <= 1'b1;
    settle;
    ph <= 8'h11;
    settle;
    rdchk(8'h84, 8'h5a);
  endtask
  task t_events;
    rdchk(8'h85, 8'h00);
    for (int i = 0; i < 5; i++) begin
      ev[i] <= 1'b1;
      settle;
      rdchk(8'h85, 8'((1 << (i + 1)) - 1));
    end
    ev[0] <= 1'b0;
    rdy <= 1'b1;
    ini <= 1'b1;
    settle;
    rdchk(8'h85, 8'hbf);
    chk("irq masked", 8'h00, {7'h0, irq});
    rdchk(8'h86, 8'h00);
    vdsr_host_model_inst.bus_wr(8'h1d, 8'h01);
    settle;
    rdchk(8'h1d, 8'h01);
    chk("irq on", 8'h01, {7'h0, irq});
    rdchk(8'h86, 8'h01);
    vdsr_host_model_inst.bus_wr(8'h1c, 8'h00);
    rdchk(8'h85, 8'hbf);
    vdsr_host_model_inst.bus_wr(8'h1c, 8'h01);
    settle;
    rdchk(8'h85, 8'hbe);
    chk("irq off", 8'h00, {7'h0, irq});
    rdchk(8'h86, 8'h00);
    vdsr_host_model_inst.bus_wr(8'h1c, 8'h1e);
    rdchk(8'h85, 8'ha0);
    vdsr_host_model_inst.bus_wr(8'h85, 8'hff);
    rdchk(8'h85, 8'ha0);
  endtask
  initial begin
    sys_rst_in = 1'b1;
    {pal, fld, frz, subcarrier_to_hsync_phase, rdy, ini, sq} = 7'h00;
    ev = 5'h00;
    gain = 8'h00;
    ph = 8'h00;
    line = 10'h000;
    std = VDSR_STD_NTSC_M;
    repeat (4) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    t_status;
    t_phase;
    t_events;
    rdchk(8'h87, 8'h2a);
    rdchk(8'h90, 8'h00);
    report_and_stop;
  end
endmodule
